// file: sbd_pkg.sv
// shared constants and types for the standby, buffer and dma write command block
package sbd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FEAT = 8'h00;
  localparam logic [7:0] OFS_CNT  = 8'h04;
  localparam logic [7:0] OFS_LOW  = 8'h08;
  localparam logic [7:0] OFS_MID  = 8'h0c;
  localparam logic [7:0] OFS_HIGH = 8'h10;
  localparam logic [7:0] OFS_DEVH = 8'h14;
  localparam logic [7:0] OFS_CMD  = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_ERR  = 8'h20;
  localparam logic [7:0] OFS_DATA = 8'h24;
  localparam logic [7:0] OFS_CFG  = 8'h28;
  // command codes
  localparam logic [7:0] CMD_STANDBY     = 8'he2;
  localparam logic [7:0] CMD_STANDBY_NOW = 8'he0;
  localparam logic [7:0] CMD_WR_BUF      = 8'he8;
  localparam logic [7:0] CMD_WR_DMA      = 8'hca;
  // field positions, reset values and first chs sector
  localparam int ER_ABORT = 2;
  localparam int ER_CRC   = 7;
  localparam int DH_LBA   = 6;
  localparam int DH_DEV   = 4;
  localparam int CFG_PM   = 0;
  localparam int CFG_BUF  = 1;
  localparam int CFG_POS  = 2;
  localparam logic [2:0] CFG_RESET = 3'h3;
  localparam logic [7:0] TF_RESET  = 8'h00;
  localparam logic [7:0] CHS_FIRST = 8'h01;
  // sizes
  localparam int SECTOR_BYTES = 512;
  localparam int WORD_BYTES   = 4;
  localparam int SECTOR_WORDS = SECTOR_BYTES / WORD_BYTES;
  localparam logic [8:0] FULL_COUNT = 9'h100;
  // timing: standby timer unit
  localparam int CLK_KHZ         = 40000;
  localparam int STANDBY_UNIT_MS = 5000;
  localparam int STANDBY_UNIT_CYC = STANDBY_UNIT_MS * CLK_KHZ;
  typedef enum logic [1:0] {
    SBD_IDLE = 2'b00,
    SBD_PIO  = 2'b01,
    SBD_DMA  = 2'b10
  } sbd_state_t;
  typedef struct packed {
    logic busy;
    logic ready;
    logic fault;
    logic rsv4;
    logic dreq;
    logic rsv2;
    logic rsv1;
    logic err;
  } sbd_status_t;
  typedef struct packed {
    logic [27:0] addr;
    logic [31:0] word;
  } sbd_media_t;
endpackage

// file: sbd_cmd_engine.sv
// command engine: standby, write buffer and dma write behind an apb task file
`timescale 1ns/1ps

// Operation
// - standby enters standby; nonzero count enables timer with derived period
// - standby with zero count leaves the timer disabled
// - e0h enters standby at once, ignoring feature, count, address registers
// - immediate standby is available whenever power management is enabled
// - no power management: both standby commands abort, error bit 2
// - good end: busy 0, ready 1, fault 0, data request 0, error 0
// - error end: busy, request clear; fault on fault; error if any bit
// - abort may be set when a command cannot be completed
// - e8h takes one sector by pio data-out into the buffer
// - buffer writes and reads address the same 512-byte region
// - buffer write unsupported: answered with abort
// - cah starts a dma write
// - dma sector count 00h means 256 sectors
// - address built from low, mid, high and head nibble, lba or chs
// - head register bit 6 selects lba, zero selects chs
// - bit 4 selects the device and is reflected in every state
// - unrecoverable dma error leaves failing sector address in registers
// - crc error on dma sets crc flag together with abort
module sbd_cmd_engine #(
  parameter int UNIT_CYC = sbd_pkg::STANDBY_UNIT_CYC,
  parameter int BUF_WORDS = sbd_pkg::SECTOR_WORDS,
  parameter int SPT = 63,
  parameter int HEADS = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // apb slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // dma data stream
  input  wire logic              dmaValid,
  input  wire logic [31:0]       dmaData,
  output logic                   dmaReady,
  input  wire logic              dmaCrcError,
  // media side
  input  wire logic              mediaFail,
  input  wire logic              deviceFault,
  output logic                   mediaWe,
  output sbd_pkg::sbd_media_t    mediaOut,
  // power state
  output logic                   standbyMode,
  output logic                   timerExpired
);
  import sbd_pkg::*;

  localparam int PW = $clog2(BUF_WORDS);

  if (BUF_WORDS != SECTOR_WORDS || SPT < 1 || SPT > 255 || HEADS < 1 || HEADS > 16
      || UNIT_CYC < 1) begin : g_bad_param
    $error("sbd_cmd_engine: unsupported parameter values");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  sbd_state_t  state_q;
  sbd_status_t stat;
  logic [7:0]  feat_q, cnt_q, low_q, mid_q, high_q, devh_q, err_q;
  logic [2:0]  cfg_q;
  logic        ready_q, fault_q, busy_q, dreq_q;
  logic [31:0] buf_q [BUF_WORDS];
  logic [PW-1:0] wrPtr_q, rdPtr_q, word_q;
  logic [8:0]  remain_q;
  logic        timerEn_q;
  logic [7:0]  units_q, left_q;
  logic [31:0] tick_q;
  logic [31:0] prdata_q;
  logic        mediaWe_q;
  sbd_media_t  media_q;

  logic wrEn, rdEn, setupRd, mapped, selMine, cmdAcc, tfWr;
  logic pmOn, bufOn, isLba;
  logic [27:0] curAddr;
  logic dmaBeat, sectorEnd, dmaLast, dmaAbort;

  assign pready = 1'b1;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign setupRd = psel & ~penable & ~pwrite;
  assign mapped = hit(paddr, OFS_FEAT) | hit(paddr, OFS_CNT) | hit(paddr, OFS_LOW)
                | hit(paddr, OFS_MID) | hit(paddr, OFS_HIGH) | hit(paddr, OFS_DEVH)
                | hit(paddr, OFS_CMD) | hit(paddr, OFS_STAT) | hit(paddr, OFS_ERR)
                | hit(paddr, OFS_DATA) | hit(paddr, OFS_CFG);
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  assign pmOn = cfg_q[CFG_PM];
  assign bufOn = cfg_q[CFG_BUF];
  assign selMine = (devh_q[DH_DEV] == cfg_q[CFG_POS]);
  // task file is frozen while a command owns it
  assign tfWr = wrEn & (state_q == SBD_IDLE);
  assign cmdAcc = tfWr & hit(paddr, OFS_CMD) & selMine;
  assign isLba = devh_q[DH_LBA];
  assign curAddr = {devh_q[3:0], high_q, mid_q, low_q};

  assign dmaReady = (state_q == SBD_DMA);
  assign dmaBeat = dmaValid & dmaReady;
  assign sectorEnd = dmaBeat & (word_q == PW'(BUF_WORDS - 1));
  assign dmaLast = sectorEnd & (remain_q == 9'h001);
  assign dmaAbort = (state_q == SBD_DMA) & (dmaCrcError | mediaFail | deviceFault);

  assign stat = '{busy: busy_q, ready: ready_q, fault: fault_q, rsv4: 1'b0,
                  dreq: dreq_q, rsv2: 1'b0, rsv1: 1'b0, err: |err_q};

  // ready comes up the cycle after reset release
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // configuration register: power management, buffer support, device position
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_q <= CFG_RESET;
    end else if (tfWr && hit(paddr, OFS_CFG)) begin
      cfg_q <= pwdata[2:0];
    end
  end

  // command sequencing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= SBD_IDLE;
      busy_q <= 1'b0;
      dreq_q <= 1'b0;
    end else begin
      case (state_q)
        SBD_IDLE: begin
          if (cmdAcc && pwdata[7:0] == CMD_WR_BUF && bufOn) begin
            state_q <= SBD_PIO;
            dreq_q <= 1'b1;
          end else if (cmdAcc && pwdata[7:0] == CMD_WR_DMA) begin
            state_q <= SBD_DMA;
            busy_q <= 1'b1;
          end
        end
        SBD_PIO: begin
          if (wrEn && hit(paddr, OFS_DATA) && wrPtr_q == PW'(BUF_WORDS - 1)) begin
            state_q <= SBD_IDLE;
            dreq_q <= 1'b0;
          end
        end
        SBD_DMA: begin
          if (dmaAbort || dmaLast) begin
            state_q <= SBD_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          state_q <= SBD_IDLE;
          busy_q <= 1'b0;
          dreq_q <= 1'b0;
        end
      endcase
    end
  end

  // error register and fault flag; a new command clears both
  always_ff @(posedge clk) begin
    if (!resetn) begin
      err_q <= TF_RESET;
      fault_q <= 1'b0;
    end else if (cmdAcc) begin
      err_q <= TF_RESET;
      fault_q <= 1'b0;
      case (pwdata[7:0])
        CMD_STANDBY, CMD_STANDBY_NOW: err_q[ER_ABORT] <= ~pmOn;
        CMD_WR_BUF: err_q[ER_ABORT] <= ~bufOn;
        CMD_WR_DMA: err_q <= TF_RESET;
        default: err_q[ER_ABORT] <= 1'b1;
      endcase
    end else if (dmaAbort) begin
      err_q[ER_ABORT] <= 1'b1;
      err_q[ER_CRC] <= dmaCrcError;
      fault_q <= deviceFault;
    end
  end

  // standby mode and timer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      standbyMode <= 1'b0;
      timerEn_q <= 1'b0;
      units_q <= TF_RESET;
    end else if (cmdAcc && pmOn && pwdata[7:0] == CMD_STANDBY) begin
      standbyMode <= 1'b1;
      timerEn_q <= (cnt_q != TF_RESET);
      units_q <= cnt_q;
    end else if (cmdAcc && pmOn && pwdata[7:0] == CMD_STANDBY_NOW) begin
      standbyMode <= 1'b1;
    end else if (cmdAcc && pwdata[7:0] == CMD_WR_DMA) begin
      standbyMode <= 1'b0;
    end
  end

  // period = code times one unit; any accepted command restarts it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_q <= '0;
      left_q <= TF_RESET;
      timerExpired <= 1'b0;
    end else begin
      timerExpired <= 1'b0;
      if (cmdAcc || !timerEn_q) begin
        tick_q <= '0;
        left_q <= (cmdAcc && pwdata[7:0] == CMD_STANDBY) ? cnt_q : units_q;
      end else if (tick_q == 32'(UNIT_CYC - 1)) begin
        tick_q <= '0;
        if (left_q == 8'h01) begin
          left_q <= units_q;
          timerExpired <= 1'b1;
        end else begin
          left_q <= left_q - 8'h01;
        end
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end

  // task file; dma advances the address after each stored sector but the last so that an
  // abort leaves the failing sector in place
  always_ff @(posedge clk) begin
    if (!resetn) begin
      feat_q <= TF_RESET;
      cnt_q <= TF_RESET;
      low_q <= TF_RESET;
      mid_q <= TF_RESET;
      high_q <= TF_RESET;
      devh_q <= TF_RESET;
    end else if (tfWr) begin
      if (hit(paddr, OFS_FEAT)) begin
        feat_q <= pwdata[7:0];
      end else if (hit(paddr, OFS_CNT)) begin
        cnt_q <= pwdata[7:0];
      end else if (hit(paddr, OFS_LOW)) begin
        low_q <= pwdata[7:0];
      end else if (hit(paddr, OFS_MID)) begin
        mid_q <= pwdata[7:0];
      end else if (hit(paddr, OFS_HIGH)) begin
        high_q <= pwdata[7:0];
      end else if (hit(paddr, OFS_DEVH)) begin
        devh_q <= pwdata[7:0];
      end
    end else if (sectorEnd && !dmaAbort && !dmaLast) begin
      if (isLba) begin
        {devh_q[3:0], high_q, mid_q, low_q} <= curAddr + 28'h1;
      end else if (low_q != 8'(SPT)) begin
        low_q <= low_q + 8'h01;
      end else begin
        low_q <= CHS_FIRST;
        if (devh_q[3:0] != 4'(HEADS - 1)) begin
          devh_q[3:0] <= devh_q[3:0] + 4'h1;
        end else begin
          devh_q[3:0] <= 4'h0;
          {high_q, mid_q} <= {high_q, mid_q} + 16'h1;
        end
      end
    end
  end

  // dma sector and word counting
  always_ff @(posedge clk) begin
    if (!resetn) begin
      remain_q <= '0;
      word_q <= '0;
    end else if (cmdAcc && pwdata[7:0] == CMD_WR_DMA) begin
      remain_q <= (cnt_q == TF_RESET) ? FULL_COUNT : {1'b0, cnt_q};
      word_q <= '0;
    end else if (dmaBeat) begin
      word_q <= word_q + PW'(1);
      if (sectorEnd) begin
        remain_q <= remain_q - 9'h001;
      end
    end
  end

  // each accepted word goes to the media port with its sector address, except a word accepted in the cycle of a dma abort
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mediaWe_q <= 1'b0;
      media_q <= '0;
    end else begin
      mediaWe_q <= dmaBeat & ~dmaAbort;
      if (dmaBeat) begin
        media_q <= '{addr: curAddr, word: dmaData};
      end
    end
  end
  assign mediaWe = mediaWe_q;
  assign mediaOut = media_q;

  // one-sector buffer; both pointers restart per buffer write command so write and read
  // always meet the same region
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else if (cmdAcc && pwdata[7:0] == CMD_WR_BUF) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else if (state_q == SBD_PIO && wrEn && hit(paddr, OFS_DATA)) begin
      wrPtr_q <= wrPtr_q + PW'(1);
    end else if (state_q == SBD_IDLE && rdEn && hit(paddr, OFS_DATA)) begin
      rdPtr_q <= rdPtr_q + PW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (state_q == SBD_PIO && wrEn && hit(paddr, OFS_DATA)) begin
      buf_q[wrPtr_q] <= pwdata;
    end
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata_q <= '0;
    end else if (setupRd) begin
      if (hit(paddr, OFS_CNT)) begin
        prdata_q <= {24'h0, cnt_q};
      end else if (hit(paddr, OFS_LOW)) begin
        prdata_q <= {24'h0, low_q};
      end else if (hit(paddr, OFS_MID)) begin
        prdata_q <= {24'h0, mid_q};
      end else if (hit(paddr, OFS_HIGH)) begin
        prdata_q <= {24'h0, high_q};
      end else if (hit(paddr, OFS_DEVH)) begin
        prdata_q <= {24'h0, devh_q};
      end else if (hit(paddr, OFS_STAT)) begin
        prdata_q <= {24'h0, stat};
      end else if (hit(paddr, OFS_ERR)) begin
        prdata_q <= {24'h0, err_q};
      end else if (hit(paddr, OFS_DATA)) begin
        prdata_q <= buf_q[rdPtr_q];
      end else if (hit(paddr, OFS_CFG)) begin
        prdata_q <= {29'h0, cfg_q};
      end else begin
        prdata_q <= '0;
      end
    end
  end

  // checks
  logic accStby, accNow, accBuf, accDma;
  assign accStby = cmdAcc && pwdata[7:0] == CMD_STANDBY;
  assign accNow = cmdAcc && pwdata[7:0] == CMD_STANDBY_NOW;
  assign accBuf = cmdAcc && pwdata[7:0] == CMD_WR_BUF;
  assign accDma = cmdAcc && pwdata[7:0] == CMD_WR_DMA;

  chk_timer_load: assert property (@(posedge clk) disable iff (!resetn)
    accStby && pmOn && cnt_q != 8'h00 |=> standbyMode && timerEn_q && units_q == $past(cnt_q))
    else $error("standby did not load the timer");
  chk_timer_off: assert property (@(posedge clk) disable iff (!resetn)
    accStby && pmOn && cnt_q == 8'h00 |=> !timerEn_q ##1 !timerExpired [*3])
    else $error("timer enabled with zero count");
  chk_standby_now: assert property (@(posedge clk) disable iff (!resetn)
    accNow && pmOn |=> standbyMode && !err_q[ER_ABORT] && $stable(timerEn_q))
    else $error("immediate standby not entered");
  chk_pm_abort: assert property (@(posedge clk) disable iff (!resetn)
    (accStby || accNow) && !pmOn |=> err_q == 8'h04 && stat.err && !$changed(standbyMode))
    else $error("standby without power management not aborted");
  chk_good_end: assert property (@(posedge clk) disable iff (!resetn)
    $fell(busy_q) && err_q == 8'h00 |-> stat.ready && !stat.fault && !stat.dreq)
    else $error("bad status after good completion");
  chk_err_bit: assert property (@(posedge clk) disable iff (!resetn)
    state_q == SBD_IDLE |-> stat.err == (err_q != 8'h00) && !busy_q)
    else $error("error bit disagrees with error register");
  chk_buf_take: assert property (@(posedge clk) disable iff (!resetn)
    accBuf && bufOn |=> dreq_q && state_q == SBD_PIO && wrPtr_q == '0)
    else $error("buffer write did not request data");
  chk_dma_count: assert property (@(posedge clk) disable iff (!resetn)
    accDma |=> remain_q == ($past(cnt_q) == 8'h00 ? 9'h100 : {1'b0, $past(cnt_q)}))
    else $error("dma sector count wrong");
  chk_crc_abort: assert property (@(posedge clk) disable iff (!resetn)
    state_q == SBD_DMA && dmaCrcError |=> err_q[ER_CRC] && err_q[ER_ABORT] && !busy_q)
    else $error("crc error not reported with abort");
  chk_dma_busy: assert property (@(posedge clk) disable iff (!resetn)
    state_q == SBD_DMA && !dmaLast && !dmaAbort |=> busy_q && remain_q != 9'h000)
    else $error("busy dropped before last sector");

  cov_buf_done: cover property (@(posedge clk) disable iff (!resetn)
    state_q == SBD_PIO ##1 state_q == SBD_IDLE);
  cov_dma_done: cover property (@(posedge clk) disable iff (!resetn) dmaLast);
  cov_timer_fire: cover property (@(posedge clk) disable iff (!resetn) timerExpired);
endmodule

// file: sbd_dma_src.sv
// dma word source standing in for the host adapter's dma channel
`timescale 1ns/1ps
module sbd_dma_src (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // bench control
  input  wire logic        enable,
  input  wire logic        slow,
  // dma stream
  input  wire logic        dmaReady,
  output logic             dmaValid,
  output logic [31:0]      dmaData
);
  logic [15:0] wordIdx_q;
  // word k carries 5a000000h + k; idle data toggles so a stale word never looks valid
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wordIdx_q <= 16'h0;
      dmaValid  <= 1'b0;
      dmaData   <= 32'h0;
    end else if (!enable) begin
      wordIdx_q <= 16'h0;
      dmaValid  <= 1'b0;
      dmaData   <= ~dmaData;
    end else if (dmaValid && dmaReady) begin
      wordIdx_q <= wordIdx_q + 16'h1;
      dmaValid  <= !slow;
      dmaData   <= slow ? ~dmaData : 32'h5a000000 + {16'h0, wordIdx_q} + 32'h1;
    end else if (!dmaValid) begin
      dmaValid  <= 1'b1;
      dmaData   <= 32'h5a000000 + {16'h0, wordIdx_q};
    end
  end
endmodule

// file: tb_top.sv
// self-checking bench for the standby, buffer and dma write command engine
`timescale 1ns/1ps
module tb_top;
  import sbd_pkg::*;
  localparam int UNIT = 4;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dmaData;
  logic dmaValid, dmaReady, dmaCrcError, mediaFail, deviceFault, mediaWe;
  logic standbyMode, timerExpired, srcEn, srcSlow, chsMode;
  sbd_media_t mediaOut;
  logic [27:0] curAddr;
  int n_mismatch, n_tests, nWe;

  sbd_cmd_engine #(.UNIT_CYC(UNIT)) DUT (.clk(clk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dmaValid(dmaValid), .dmaData(dmaData),
    .dmaReady(dmaReady), .dmaCrcError(dmaCrcError), .mediaFail(mediaFail),
    .deviceFault(deviceFault), .mediaWe(mediaWe), .mediaOut(mediaOut),
    .standbyMode(standbyMode), .timerExpired(timerExpired));
  sbd_dma_src src (.clk(clk), .resetn(resetn), .enable(srcEn), .slow(srcSlow),
    .dmaReady(dmaReady), .dmaValid(dmaValid), .dmaData(dmaData));

  task automatic fail_msg(input string m);
    $display("[ERR] %0t %s", $time, m);
    n_mismatch++;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) fail_msg($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) fail_msg($sformatf("%s got %b", m, got));
  endtask
  task automatic chk_num(input int got, input int exp, input string m);
    n_tests++;
    if (got != exp) fail_msg($sformatf("%s got %0d exp %0d", m, got, exp));
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fail_msg("apb hang");
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    apb(1'b0, a, 32'h0, v);
  endtask
  task automatic cmd(input logic [7:0] c);
    logic [31:0] s;
    int k;
    k = 0;
    do begin
      rd(OFS_STAT, s);
      k++;
    end while (s[6] !== 1'b1 && k < 20);
    wr(OFS_CMD, {24'h0, c});
  endtask
  task automatic expect_end(input logic [7:0] st, input logic [7:0] er);
    logic [31:0] v;
    rd(OFS_STAT, v);
    chk_reg(v, {24'h0, st}, "status");
    rd(OFS_ERR, v);
    chk_reg(v, {24'h0, er}, "error");
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    int k;
    k = 0;
    do begin
      rd(OFS_STAT, s);
      k++;
    end while (s[7] !== 1'b0 && k < 20000);
    if (k >= 20000) fail_msg("busy stuck");
    srcEn <= 1'b0;
  endtask

  function automatic logic [27:0] next_addr(input logic [27:0] a, input logic cylinder_head_sector_addressing);
    if (!cylinder_head_sector_addressing) return a + 28'h1;
    if (a[7:0] < 8'h3f) return {a[27:8], a[7:0] + 8'h01};
    if (a[27:24] < 4'hf) return {a[27:24] + 4'h1, a[23:8], 8'h01};
    return {4'h0, a[23:8] + 16'h0001, 8'h01};
  endfunction

  // media side: every stored word against the address walk and the source pattern
  always @(posedge clk) begin
    if (resetn === 1'b1 && mediaWe === 1'b1) begin
      chk_reg({4'h0, mediaOut.addr}, {4'h0, curAddr}, "media addr");
      chk_reg(mediaOut.word, 32'h5a000000 + 32'(nWe), "media word");
      nWe++;
      if (nWe % 128 == 0) curAddr = next_addr(curAddr, chsMode);
    end
  end

  task automatic dma_start(input logic logical_block_addressing, input logic [27:0] a, input logic [7:0] n,
                           input logic slow);
    logic [31:0] s;
    wr(OFS_CNT, {24'h0, n});
    wr(OFS_LOW, {24'h0, a[7:0]});
    wr(OFS_MID, {24'h0, a[15:8]});
    wr(OFS_HIGH, {24'h0, a[23:16]});
    wr(OFS_DEVH, {25'h0, logical_block_addressing, 2'b00, a[27:24]});
    curAddr = a;
    chsMode = !logical_block_addressing;
    nWe = 0;
    srcSlow <= slow;
    cmd(CMD_WR_DMA);
    rd(OFS_STAT, s);
    chk_bit(s[7], 1'b1, "busy in dma");
    chk_bit(dmaReady, 1'b1, "dma ready");
    srcEn <= 1'b1;
  endtask
  task automatic t_dma(input logic logical_block_addressing, input logic [27:0] a, input logic [7:0] n,
                       input logic slow);
    dma_start(logical_block_addressing, a, n, slow);
    wait_idle;
    expect_end(8'h40, 8'h00);
    chk_num(nWe, (n == 8'h0 ? 256 : int'(n)) * 128, "words");
    chk_bit(standbyMode, 1'b0, "standby after dma");
    chk_bit(dmaReady, 1'b0, "dma ready after end");
  endtask
  task automatic t_dma_error(input logic crc);
    logic [31:0] v;
    dma_start(1'b1, 28'h0000200, 8'h03, 1'b0);
    while (nWe < 130) @(posedge clk);
    dmaCrcError <= crc;
    mediaFail <= !crc;
    deviceFault <= !crc;
    @(posedge clk);
    dmaCrcError <= 1'b0;
    mediaFail <= 1'b0;
    deviceFault <= 1'b0;
    wait_idle;
    expect_end(crc ? 8'h41 : 8'h61, crc ? 8'h84 : 8'h04);
    rd(OFS_LOW, v);
    chk_reg(v, 32'h01, "fail sector");
    rd(OFS_MID, v);
    chk_reg(v, 32'h02, "fail mid");
    rd(OFS_DEVH, v);
    chk_reg(v & 32'h5f, 32'h40, "fail head");
  endtask

  task automatic t_standby;
    int k;
    wr(OFS_CNT, 32'h2);
    cmd(CMD_STANDBY);
    expect_end(8'h40, 8'h00);
    chk_bit(standbyMode, 1'b1, "standby");
    k = 0;
    while (timerExpired !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (timerExpired !== 1'b1 && k < 100);
    chk_num(k, 2 * UNIT, "timer period");
    wr(OFS_CNT, 32'h0);
    cmd(CMD_STANDBY);
    expect_end(8'h40, 8'h00);
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (timerExpired === 1'b1) k++;
    end
    chk_num(k, 0, "timer off");
  endtask
  task automatic t_refusals;
    logic [31:0] v;
    wr(OFS_CFG, 32'h2);
    cmd(CMD_STANDBY);
    expect_end(8'h41, 8'h04);
    cmd(CMD_STANDBY_NOW);
    expect_end(8'h41, 8'h04);
    wr(OFS_CFG, 32'h1);
    cmd(CMD_WR_BUF);
    expect_end(8'h41, 8'h04);
    wr(OFS_CFG, 32'h3);
    rd(8'h3c, v);
    chk_bit(lastErr, 1'b1, "unmapped");
  endtask
  task automatic t_buffer;
    logic [31:0] v;
    cmd(CMD_WR_BUF);
    rd(OFS_STAT, v);
    chk_reg(v, 32'h48, "data request");
    for (int i = 0; i < 128; i++) wr(OFS_DATA, 32'hb0f00000 + 32'(i));
    expect_end(8'h40, 8'h00);
    for (int i = 0; i < 128; i++) begin
      rd(OFS_DATA, v);
      chk_reg(v, 32'hb0f00000 + 32'(i), "buffer word");
    end
  endtask
  task automatic t_select_and_now;
    logic [31:0] v;
    int k;
    wr(OFS_DEVH, 32'h10);
    cmd(CMD_STANDBY_NOW);
    rd(OFS_DEVH, v);
    chk_reg(v & 32'h10, 32'h10, "select bit");
    chk_bit(standbyMode, 1'b0, "other drive");
    wr(OFS_DEVH, 32'h0);
    wr(OFS_FEAT, 32'hff);
    wr(OFS_CNT, 32'h05);
    wr(OFS_LOW, 32'h33);
    cmd(CMD_STANDBY_NOW);
    expect_end(8'h40, 8'h00);
    chk_bit(standbyMode, 1'b1, "standby now");
    // a count of 5 would fire within 20 cycles if immediate standby had loaded it
    k = 0;
    repeat (30) begin
      @(posedge clk);
      if (timerExpired === 1'b1) k++;
    end
    chk_num(k, 0, "count ignored");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // budget: the 256-sector run dominates at about 33k cycles, all else under 5k
  initial begin
    #(60000 * 25);
    fail_msg("timeout");
    give_verdict;
  end
  initial begin
    {psel, penable, pwrite, dmaCrcError, mediaFail, deviceFault, srcEn, srcSlow} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    resetn = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    nWe = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    expect_end(8'h40, 8'h00);
    t_standby;
    t_refusals;
    t_buffer;
    t_dma(1'b1, 28'h0ffffff, 8'h02, 1'b1);
    t_dma(1'b0, {4'hf, 16'h0012, 8'h3f}, 8'h00, 1'b0);
    t_dma_error(1'b1);
    t_dma_error(1'b0);
    t_select_and_now;
    give_verdict;
  end
endmodule
